//--- design/mad_defs.vh
// Register map, field positions and reset values of the alert detector
`ifndef MAD_DEFS_VH
`define MAD_DEFS_VH

// Word addresses on the register port
`define MAD_OFS_SENSE     8'h02
`define MAD_OFS_ALERT     8'h03
`define MAD_OFS_POWER     8'h27
`define MAD_OFS_RES_HI    8'h28
`define MAD_OFS_RES_LO    8'h29

// Sensing configuration word
`define MAD_HALL_HI       20
`define MAD_HALL_LO       19
`define MAD_HALL_INNER    2'h0
`define MAD_HALL_SUM      2'h2
`define MAD_CHEN_LO       6
`define MAD_CHEN_HI       8
`define MAD_LATCH_BIT     5
`define MAD_SENSE_RST     32'h000001c0

// Alert configuration word
`define MAD_THR_W         6
`define MAD_THR_HI        17
`define MAD_AEN_LO        18
`define MAD_AEN_HI        20
`define MAD_NV_EN_BIT     21
`define MAD_NV_FLAG_BIT   22
`define MAD_MODE_BIT      23
`define MAD_SIGNED_BIT    24
`define MAD_ALERT_RST     32'h00000000

// Power word
`define MAD_PM_HI         1
`define MAD_PM_LO         0
`define MAD_PM_DUTY       2'h2
`define MAD_POWER_RST     32'h00000000

// Result words
`define MAD_RES_ALERT_BIT 6
`define MAD_MSB_W         8
`define MAD_LSB_W         4

// Threshold scaling shifts
`define MAD_USH           5
`define MAD_SSH           6

`endif

//--- design/mad_src_sel.v
// Element source selection: inner elements or summed outer pairs
`timescale 1ns/1ns
`include "mad_defs.vh"
module mad_src_sel #(
	parameter DW = 12
) (
	input  wire [1:0]    hall_mode,
	input  wire [DW-1:0] x_in,
	input  wire [DW-1:0] y_in,
	input  wire [DW-1:0] z_in,
	input  wire [DW-1:0] x_east,
	input  wire [DW-1:0] x_west,
	input  wire [DW-1:0] y_north,
	input  wire [DW-1:0] y_south,
	output wire [DW-1:0] x_out,
	output wire [DW-1:0] y_out,
	output wire [DW-1:0] z_out
);
	wire [DW:0] x_sum;
	wire [DW:0] y_sum;

	assign x_sum = {x_east[DW-1], x_east} + {x_west[DW-1], x_west};
	assign y_sum = {y_north[DW-1], y_north} + {y_south[DW-1], y_south};

	// Saturate the pair sum rather than wrap, so the sign is never flipped
	function [DW-1:0] sat;
		input [DW:0] s;
		begin
			if (s[DW] != s[DW-1])
				sat = s[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
			else
				sat = s[DW-1:0];
		end
	endfunction

	// Reserved codes behave as inner-element operation
	assign x_out = (hall_mode == `MAD_HALL_SUM) ? sat(x_sum) : x_in;
	assign y_out = (hall_mode == `MAD_HALL_SUM) ? sat(y_sum) : y_in;
	assign z_out = z_in;
endmodule

//--- design/mad_axis_cmp.v
// One axis comparator: level or change, signed or unsigned limit
`timescale 1ns/1ns
`include "mad_defs.vh"
module mad_axis_cmp #(
	parameter DW = 12
) (
	input  wire [DW-1:0]        data,
	input  wire [DW-1:0]        ref_data,
	input  wire [`MAD_THR_W-1:0] thr_field,
	input  wire                 signed_en,
	input  wire                 delta_en,
	output wire                 hit
);
	localparam W = DW + 2;

	wire signed [W-1:0] val;
	wire signed [W-1:0] mag;
	wire signed [W-1:0] thr_u;
	wire signed [W-1:0] thr_s;
	wire [`MAD_THR_W:0] fp1_u;
	wire signed [`MAD_THR_W:0] fp1_s;

	// Change mode works on the difference to the stored reference
	assign val = delta_en ? ({{2{data[DW-1]}}, data} -
		{{2{ref_data[DW-1]}}, ref_data}) : {{2{data[DW-1]}}, data};
	assign mag = val[W-1] ? -val : val;

	assign fp1_u = {1'b0, thr_field} + 1'b1;
	assign fp1_s = {thr_field[`MAD_THR_W-1], thr_field} + 1'b1;
	assign thr_u = ({{(W-`MAD_THR_W-1){1'b0}}, fp1_u} << `MAD_USH)
		- 1'b1;
	assign thr_s = ({{(W-`MAD_THR_W-1){fp1_s[`MAD_THR_W]}}, fp1_s}
		<< `MAD_SSH) - {{(W-1){1'b0}}, ~thr_field[`MAD_THR_W-1]};

	// Negative signed limit fires toward the negative side only
	assign hit = signed_en ? (thr_field[`MAD_THR_W-1] ? (val <= thr_s)
		: (val >= thr_s)) : (mag >= thr_u);
endmodule

//--- design/mad_top.v
// Per-axis magnetic alert detector with register port and alert pin
`timescale 1ns/1ns
`include "mad_defs.vh"

module mad_top #(
	parameter DW = 12
) (
	input  wire          mclk,
	input  wire          rst,
	input  wire          reg_wr,
	input  wire          reg_rd,
	input  wire [7:0]    reg_addr,
	input  wire [31:0]   reg_wdata,
	output reg  [31:0]   reg_rdata_r,
	output reg           reg_rvld_r,
	input  wire          smp_vld,
	input  wire [DW-1:0] x_inner,
	input  wire [DW-1:0] y_inner,
	input  wire [DW-1:0] z_inner,
	input  wire [DW-1:0] x_east,
	input  wire [DW-1:0] x_west,
	input  wire [DW-1:0] y_north,
	input  wire [DW-1:0] y_south,
	output reg           alert_n_r,
	output reg           nv_wr_r,
	output reg  [1:0]    duty_cycled_power_mode_r,
	output reg  [2:0]    ch_en_r
);
	////////////////////////////////////////////////////////////////////
	// Configuration and state
	reg  [31:0]     sense_r;
	reg  [31:0]     alert_cfg_r;
	reg  [31:0]     power_r;
	reg  [3*DW-1:0] smp_r;
	reg  [3*DW-1:0] ref_r;
	reg             ref_ok_r;
	reg             cond_r;
	reg             status_r;
	reg             nv_flag_r;

	reg  [31:0]     sense_nxt;
	reg  [31:0]     alert_cfg_nxt;
	reg  [31:0]     power_nxt;
	reg  [3*DW-1:0] ref_nxt;
	reg             ref_ok_nxt;
	reg             cond_nxt;
	reg             status_nxt;
	reg             nv_flag_nxt;
	reg             nv_wr_nxt;
	reg  [31:0]     rdata_nxt;

	wire [DW-1:0]   x_sel;
	wire [DW-1:0]   y_sel;
	wire [DW-1:0]   z_sel;
	wire [3*DW-1:0] cur;
	wire [2:0]      hit;
	wire [2:0]      armed;
	wire            det;
	wire            eval;
	wire            event_p;
	wire            latch_en;
	wire            delta_en;
	wire            signed_en;
	wire            nv_en;
	wire            duty_on;
	wire            duty_entry;
	wire            wr_sense;
	wire            wr_alert;
	wire            wr_power;
	wire            wr_res;
	wire            status_clr;
	wire [1:0]      pm_wr;
	wire [`MAD_MSB_W-1:0] x_msb;
	wire [`MAD_MSB_W-1:0] y_msb;
	wire [`MAD_MSB_W-1:0] z_msb;
	wire [`MAD_LSB_W-1:0] x_lsb;
	wire [`MAD_LSB_W-1:0] y_lsb;
	wire [`MAD_LSB_W-1:0] z_lsb;

	////////////////////////////////////////////////////////////////////
	// Decode
	assign wr_sense   = reg_wr && (reg_addr == `MAD_OFS_SENSE);
	assign wr_alert   = reg_wr && (reg_addr == `MAD_OFS_ALERT);
	assign wr_power   = reg_wr && (reg_addr == `MAD_OFS_POWER);
	assign wr_res     = reg_wr && (reg_addr == `MAD_OFS_RES_HI);
	assign status_clr = wr_res && reg_wdata[`MAD_RES_ALERT_BIT];
	assign pm_wr      = reg_wdata[`MAD_PM_HI:`MAD_PM_LO];

	assign latch_en   = sense_r[`MAD_LATCH_BIT];
	assign delta_en   = alert_cfg_r[`MAD_MODE_BIT];
	assign signed_en  = alert_cfg_r[`MAD_SIGNED_BIT];
	assign nv_en      = alert_cfg_r[`MAD_NV_EN_BIT];
	assign duty_on    = (power_r[`MAD_PM_HI:`MAD_PM_LO] == `MAD_PM_DUTY);
	// Entry is the write that moves the mode word into duty cycling
	assign duty_entry = wr_power && (pm_wr == `MAD_PM_DUTY) && !duty_on;

	////////////////////////////////////////////////////////////////////
	// Source selection and per-axis comparison
	mad_src_sel #(
		.DW(DW)
	) u_sel (
		.hall_mode (sense_r[`MAD_HALL_HI:`MAD_HALL_LO]),
		.x_in      (x_inner),
		.y_in      (y_inner),
		.z_in      (z_inner),
		.x_east    (x_east),
		.x_west    (x_west),
		.y_north   (y_north),
		.y_south   (y_south),
		.x_out     (x_sel),
		.y_out     (y_sel),
		.z_out     (z_sel)
	);

	assign cur = {z_sel, y_sel, x_sel};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_axis
			mad_axis_cmp #(
				.DW(DW)
			) u_cmp (
				.data      (cur[g*DW +: DW]),
				.ref_data  (ref_r[g*DW +: DW]),
				.thr_field (alert_cfg_r[g*`MAD_THR_W +: `MAD_THR_W]),
				.signed_en (signed_en),
				.delta_en  (delta_en),
				.hit       (hit[g])
			);
			assign armed[g] = alert_cfg_r[`MAD_AEN_LO + g] &&
				sense_r[`MAD_CHEN_LO + g];
		end
	endgenerate

	assign det = |(hit & armed);

	// Change mode only judges samples taken after a reference exists
	assign eval    = smp_vld && (!delta_en || ref_ok_r);
	assign event_p = eval && det;

	////////////////////////////////////////////////////////////////////
	// Next-state logic: configuration words
	always @* begin
		sense_nxt     = sense_r;
		alert_cfg_nxt = alert_cfg_r;
		power_nxt     = power_r;
		if (wr_sense) begin
			sense_nxt = reg_wdata;
		end
		if (wr_alert) begin
			alert_cfg_nxt = reg_wdata;
		end
		if (wr_power) begin
			power_nxt = reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Next-state logic: change reference
	always @* begin
		ref_nxt    = ref_r;
		ref_ok_nxt = ref_ok_r;
		// Reference is the last result held when duty cycling starts
		if (duty_entry) begin
			ref_nxt    = smp_r;
			ref_ok_nxt = 1'b1;
		end else if (wr_power && (pm_wr != `MAD_PM_DUTY)) begin
			ref_ok_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Next-state logic: condition, status and log flag
	always @* begin
		cond_nxt    = cond_r;
		status_nxt  = status_r;
		nv_flag_nxt = nv_flag_r;
		nv_wr_nxt   = 1'b0;

		// Config changes act at the next sample, except that clearing the latch bit takes effect at once
		if (eval) begin
			cond_nxt = det;
		end else if (smp_vld && delta_en && !ref_ok_r) begin
			cond_nxt = 1'b0;
		end

		// Latched: a new event wins over a clear in the same cycle
		if (latch_en) begin
			status_nxt = (status_r && !status_clr) || event_p;
		end else begin
			status_nxt = cond_nxt;
		end

		// Log flag follows host writes, but an event wins when nv_en is set
		if (wr_alert) begin
			nv_flag_nxt = reg_wdata[`MAD_NV_FLAG_BIT];
		end
		// Writing only on a fresh set spares the limited write count
		if (event_p && nv_en) begin
			nv_flag_nxt = 1'b1;
			nv_wr_nxt   = !nv_flag_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result fields: high bits and low bits of each axis
	assign x_msb = smp_r[DW-1 -: `MAD_MSB_W];
	assign y_msb = smp_r[2*DW-1 -: `MAD_MSB_W];
	assign z_msb = smp_r[3*DW-1 -: `MAD_MSB_W];
	assign x_lsb = smp_r[0 +: `MAD_LSB_W];
	assign y_lsb = smp_r[DW +: `MAD_LSB_W];
	assign z_lsb = smp_r[2*DW +: `MAD_LSB_W];

	////////////////////////////////////////////////////////////////////
	// Read mux
	always @* begin
		rdata_nxt = 32'h00000000;
		case (reg_addr)
		`MAD_OFS_SENSE: begin
			rdata_nxt = sense_r;
		end
		`MAD_OFS_ALERT: begin
			rdata_nxt = alert_cfg_r;
			rdata_nxt[`MAD_NV_FLAG_BIT] = nv_flag_r;
		end
		`MAD_OFS_POWER: begin
			rdata_nxt = power_r;
		end
		`MAD_OFS_RES_HI: begin
			rdata_nxt[31:24] = x_msb;
			rdata_nxt[23:16] = y_msb;
			rdata_nxt[15:8]  = z_msb;
			rdata_nxt[`MAD_RES_ALERT_BIT] = status_r;
		end
		`MAD_OFS_RES_LO: begin
			rdata_nxt[19:16] = x_lsb;
			rdata_nxt[11:8]  = y_lsb;
			rdata_nxt[3:0]   = z_lsb;
		end
		default: begin
			rdata_nxt = 32'h00000000;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Configuration registers
	// Whole words are stored; unused bits read back as written
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sense_r     <= `MAD_SENSE_RST;
			alert_cfg_r <= `MAD_ALERT_RST;
			power_r     <= `MAD_POWER_RST;
		end else begin
			sense_r     <= sense_nxt;
			alert_cfg_r <= alert_cfg_nxt;
			power_r     <= power_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latest sample and change reference
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			smp_r    <= {(3*DW){1'b0}};
			ref_r    <= {(3*DW){1'b0}};
			ref_ok_r <= 1'b0;
		end else begin
			if (smp_vld) begin
				smp_r <= cur;
			end
			ref_r    <= ref_nxt;
			ref_ok_r <= ref_ok_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alert condition, status, pin and log request
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cond_r    <= 1'b0;
			status_r  <= 1'b0;
			nv_flag_r <= 1'b0;
			nv_wr_r   <= 1'b0;
			alert_n_r <= 1'b1;
		end else begin
			cond_r    <= cond_nxt;
			status_r  <= status_nxt;
			nv_flag_r <= nv_flag_nxt;
			nv_wr_r   <= nv_wr_nxt;
			alert_n_r <= !status_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read port
	// Data holds until the next read, so a slow host may fetch it late
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= 32'h00000000;
			reg_rvld_r  <= 1'b0;
		end else begin
			reg_rvld_r <= reg_rd;
			if (reg_rd) begin
				reg_rdata_r <= rdata_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration mirrors on pins
	// Taken from the next value so pins agree with a written word at once; both pins reset to 0
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			duty_cycled_power_mode_r <= 2'h0;
			ch_en_r                  <= 3'h0;
		end else begin
			duty_cycled_power_mode_r <= power_nxt[`MAD_PM_HI:`MAD_PM_LO];
			ch_en_r                  <= sense_nxt[`MAD_CHEN_HI:`MAD_CHEN_LO];
		end
	end
endmodule

//--- testbench/mad_assertions.sv
// Concurrent checks on the alert detector top-level ports
`timescale 1ns/1ns
module mad_assertions (
	input wire        mclk,
	input wire        rst,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata_r,
	input wire        reg_rvld_r,
	input wire        smp_vld,
	input wire        alert_n_r,
	input wire        nv_wr_r,
	input wire [1:0]  duty_cycled_power_mode_r,
	input wire [2:0]  ch_en_r
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_alert_on_sample: assert property ($fell(alert_n_r) |-> $past(smp_vld))
		else $error("alert asserted without a sample");
	a_alert_idle_hold: assert property (!smp_vld && !reg_wr |=> $stable(alert_n_r))
		else $error("alert pin moved with no cause");
	a_status_pin_match: assert property (reg_rd && reg_addr == 8'h28
		|=> reg_rdata_r[6] == !$past(alert_n_r))
		else $error("status bit disagrees with pin");
	a_nv_with_alert: assert property (nv_wr_r |-> !alert_n_r && $past(smp_vld))
		else $error("log write without alert event");
	a_nv_single_pulse: assert property (nv_wr_r |=> !nv_wr_r)
		else $error("log write longer than one cycle");
	a_power_mode_wr: assert property (reg_wr && reg_addr == 8'h27
		|=> {30'h0, duty_cycled_power_mode_r} == ($past(reg_wdata) & 32'h3))
		else $error("power mode not taken from write");
	a_chen_copy_wr: assert property (reg_wr && reg_addr == 8'h02
		|=> {23'h0, ch_en_r, 6'h0} == ($past(reg_wdata) & 32'h1c0))
		else $error("sensing enables not taken from write");
	a_read_valid_pulse: assert property (reg_rvld_r == $past(reg_rd))
		else $error("read valid not one cycle after strobe");
endmodule

//--- testbench/mad_host.sv
// Host-side monitor counting non-volatile log requests
`timescale 1ns/1ns
module mad_host (
	input  wire       mclk,
	input  wire       rst,
	input  wire       nv_wr_r,
	output reg  [7:0] nv_cnt
);
	// Host only listens, it never drives the alert pin
	always @(posedge mclk or posedge rst) begin
		if (rst)
			nv_cnt <= 8'h00;
		else if (nv_wr_r)
			nv_cnt <= nv_cnt + 8'h01;
	end
endmodule

//--- testbench/mad_top_tb.sv
// Self-checking bench for the magnetic alert detector
`timescale 1ns/1ns
module mad_top_tb;
	reg         mclk, rst, reg_wr, reg_rd, smp_vld;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata;
	reg  [11:0] xi, yi, zi, xe, xw, yn, ys;
	wire [31:0] reg_rdata_r;
	wire        reg_rvld_r, alert_n_r, nv_wr_r;
	wire [1:0]  duty_cycled_power_mode_r;
	wire [2:0]  ch_en_r;
	wire [7:0]  nv_cnt;
	integer     fails, comparisons, i;
	reg  [44:0] tbl [0:12];
	mad_top uut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.reg_rvld_r(reg_rvld_r), .smp_vld(smp_vld), .x_inner(xi),
		.y_inner(yi), .z_inner(zi), .x_east(xe), .x_west(xw),
		.y_north(yn), .y_south(ys), .alert_n_r(alert_n_r),
		.nv_wr_r(nv_wr_r), .ch_en_r(ch_en_r),
		.duty_cycled_power_mode_r(duty_cycled_power_mode_r));
	mad_host host (.mclk(mclk), .rst(rst), .nv_wr_r(nv_wr_r),
		.nv_cnt(nv_cnt));
	////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			#10 reg_wr = 1'h1;
			reg_addr = a;
			reg_wdata = d;
			@(posedge mclk);
			#10 reg_wr = 1'h0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			@(posedge mclk);
			#10 reg_rd = 1'h1;
			reg_addr = a;
			@(posedge mclk);
			#10 reg_rd = 1'h0;
			chk(reg_rdata_r & m, e);
		end
	endtask
	// Outer pairs carry x+1 and y+2, so a wrong source shows in the MSBs
	task smp(input [11:0] x, input [11:0] y, input [11:0] z);
		begin
			@(posedge mclk);
			#10 smp_vld = 1'h1;
			xi = x;
			yi = y;
			zi = z;
			xe = x;
			xw = 12'h001;
			yn = y;
			ys = 12'h002;
			@(posedge mclk);
			#10 smp_vld = 1'h0;
		end
	endtask
	task conclude;
		begin
			$display("fails %0d comparisons %0d", fails, comparisons);
			if (fails == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#100000;
		fails = fails + 1;
		conclude;
	end
	initial begin
		{reg_wr, reg_rd, smp_vld, reg_addr, reg_wdata} = 43'h0;
		{xi, yi, zi, xe, xw, yn, ys} = 84'h0;
		fails = 0;
		comparisons = 0;
		// Entries: alert word, X sample, expected pin level
		tbl = '{{32'h00040002, 12'h05e, 1'h1}, {32'h00040002, 12'h05f, 1'h0},
			{32'h00040002, 12'hfa1, 1'h0}, {32'h00040002, 12'hfa2, 1'h1},
			{32'h01040001, 12'h07e, 1'h1}, {32'h01040001, 12'h07f, 1'h0},
			{32'h01040001, 12'hf00, 1'h1}, {32'h0104003f, 12'hfff, 1'h0},
			{32'h0104003f, 12'h001, 1'h1}, {32'h00000002, 12'h7ff, 1'h1},
			{32'h00080040, 12'h000, 1'h0}, {32'h00100000, 12'h000, 1'h0},
			{32'h00101000, 12'h000, 1'h1}};
		rst = 1'h1;
		repeat (3) @(posedge mclk);
		#10 rst = 1'h0;
		chk({31'h0, alert_n_r}, 32'h1);
		rd(8'h02, 32'hffffffff, 32'h000001c0);
		chk({29'h0, ch_en_r}, 32'h7);
		rd(8'h03, 32'hffffffff, 32'h0);
		rd(8'h27, 32'hffffffff, 32'h0);
		rd(8'h10, 32'hffffffff, 32'h0);
		wr(8'h02, 32'h001001c0);
		smp(12'h12f, 12'h01e, 12'h321);
		rd(8'h28, 32'hffffff00, 32'h13023200);
		rd(8'h29, 32'h000f0f0f, 32'h00000001);
		wr(8'h02, 32'h000001c0);
		smp(12'h12f, 12'h01e, 12'h321);
		rd(8'h28, 32'hffffff00, 32'h12013200);
		wr(8'h02, 32'h000801c0);
		smp(12'h12f, 12'h01e, 12'h321);
		rd(8'h28, 32'hffffff00, 32'h12013200);
		for (i = 0; i < 13; i = i + 1) begin
			wr(8'h03, tbl[i][44:13]);
			smp(tbl[i][12:1], 12'h07f, 12'h020);
			chk({31'h0, alert_n_r}, {31'h0, tbl[i][0]});
		end
		wr(8'h02, 32'h000001e0);
		wr(8'h03, 32'h00040002);
		smp(12'h05f, 12'h0, 12'h0);
		smp(12'h000, 12'h0, 12'h0);
		chk({31'h0, alert_n_r}, 32'h0);
		rd(8'h28, 32'h00000040, 32'h00000040);
		wr(8'h28, 32'h00000040);
		chk({31'h0, alert_n_r}, 32'h1);
		wr(8'h02, 32'h00000180);
		smp(12'h05f, 12'h0, 12'h0);
		chk({31'h0, alert_n_r}, 32'h1);
		wr(8'h02, 32'h000001c0);
		wr(8'h03, 32'h00240002);
		smp(12'h05f, 12'h0, 12'h0);
		smp(12'h05f, 12'h0, 12'h0);
		rd(8'h03, 32'h00400000, 32'h00400000);
		chk({24'h0, nv_cnt}, 32'h1);
		wr(8'h03, 32'h00840002);
		smp(12'h100, 12'h0, 12'h0);
		chk({31'h0, alert_n_r}, 32'h1);
		wr(8'h27, 32'h00000002);
		chk({30'h0, duty_cycled_power_mode_r}, 32'h2);
		smp(12'h15e, 12'h0, 12'h0);
		chk({31'h0, alert_n_r}, 32'h1);
		smp(12'h15f, 12'h0, 12'h0);
		chk({31'h0, alert_n_r}, 32'h0);
		conclude;
	end
endmodule
bind mad_top mad_assertions chk_i (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata_r(reg_rdata_r), .reg_rvld_r(reg_rvld_r), .smp_vld(smp_vld),
	.alert_n_r(alert_n_r), .nv_wr_r(nv_wr_r), .ch_en_r(ch_en_r),
	.duty_cycled_power_mode_r(duty_cycled_power_mode_r));
